// File: lb_clock_div.sv
`timescale 1ns/100ps
`default_nettype none
module lb_clock_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic div2,
  lb_sync_if.divider sif
);
  import lb_pkg::*;
  logic [1:0] phase_ff;
  logic clk_out_ff;
  wire [1:0] last = div2 ? DIV2_LAST : DIV4_LAST;
  wire [1:0] mid_ph = div2 ? DIV2_MID : DIV4_MID;
  // >= so that a ratio change mid-period cannot run the phase away
  wire tick = phase_ff >= last;

  assign sif.tick = tick;
  assign sif.mid = phase_ff == mid_ph;
  assign sif.clk_out = clk_out_ff;

  // local clock rises on the edge after tick, falls after mid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_ff <= 2'h0;
      clk_out_ff <= 1'b0;
    end else begin
      phase_ff <= tick ? 2'h0 : 2'(phase_ff + 2'h1);
      clk_out_ff <= tick ? 1'b1 : (sif.mid ? 1'b0 : clk_out_ff); // R21
    end
  end
endmodule
`default_nettype wire

// File: lb_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lb_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_n,
  input wire logic breq_n,
  input wire logic [31:0] ad_in,
  lb_sync_if.sync sif
);
  logic [3:0] ack_ff;
  logic [1:0] breq_ff;
  logic [31:0] ad1_ff;
  logic [31:0] ad2_ff;

  assign sif.ack_direct_n = ack_ff[1];
  assign sif.ack_dsync_n = ack_ff[3];
  assign sif.breq_n = breq_ff[1];
  assign sif.ad_in = ad2_ff;

  // two stages for any pin; the ack gets two more for the slow mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 4'hF;
      breq_ff <= 2'h3;
      ad1_ff <= 32'h0000_0000;
      ad2_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= {ack_ff[2:0], ack_n}; // R22
      breq_ff <= {breq_ff[0], breq_n};
      ad1_ff <= ad_in;
      ad2_ff <= ad1_ff;
    end
  end
endmodule
`default_nettype wire

// File: lb_pkg.sv
package lb_pkg;
  // apb map, byte addresses
  localparam int APB_AW = 12;
  localparam logic [11:0] CFG_OFS = 12'h000;
  localparam logic [11:0] ADDR_OFS = 12'h004;
  localparam logic [11:0] CTRL_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00C;
  localparam logic [11:0] BUF_OFS = 12'h010;
  localparam logic [11:0] BUF_END = 12'h030;
  localparam logic [11:0] TIM_OFS = 12'h040;
  localparam logic [11:0] TIM_END = 12'h05C;
  // local_config_reg fields
  localparam int CFG_DIV2_BIT = 0;
  localparam int CFG_ARB_BIT = 1;
  localparam int CFG_IRQEN_BIT = 2;
  localparam int CFG_WD_LSB = 16;
  // request control fields
  localparam int CTRL_BE_LSB = 0;
  localparam int CTRL_WR_BIT = 4;
  localparam int CTRL_BLK_BIT = 5;
  localparam int CTRL_SEL_LSB = 6;
  localparam int CTRL_GO_BIT = 31;
  localparam int CTRL_W = 9;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TMO_BIT = 1;
  localparam int STAT_GRANT_BIT = 2;
  // select_timing_reg fields
  localparam int TM_POL_BIT = 0;
  localparam int TM_SIZE_LSB = 1;
  localparam int TM_RDY_BIT = 3;
  localparam int TM_RSYNC_BIT = 4;
  localparam int TM_CSON_LSB = 5;
  localparam int TM_CONSET_LSB = 8;
  localparam int TM_WID_LSB = 11;
  localparam int TM_COFH_LSB = 15;
  localparam int TM_CSOFF_LSB = 18;
  localparam int TM_IDLE_LSB = 21;
  localparam int TM_SUBW_LSB = 25;
  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] TIM_RST = 32'h0000_0000;
  // sizes and counts
  localparam int NUM_SEL = 7;
  localparam int BUF_WORDS = 8;
  localparam int WD_W = 12;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] DIV4_MID = 2'h1;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV2_MID = 2'h0;
  localparam logic [4:0] WORD_UNITS_LAST = 5'h03;
  localparam logic [4:0] BLOCK_UNITS_LAST = 5'h1F;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CHECK, ST_ADDR, ST_CS_SETUP, ST_STB_SETUP, ST_STROBE,
    ST_BURST_GAP, ST_CS_HOLD, ST_ADDR_HOLD, ST_IDLE_GAP
  } lb_state_t;
endpackage

// File: lb_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lb_sync_if;
  logic tick;
  logic mid;
  logic clk_out;
  logic ack_direct_n;
  logic ack_dsync_n;
  logic breq_n;
  logic [31:0] ad_in;
  modport divider (output tick, output mid, output clk_out);
  modport sync (output ack_direct_n, output ack_dsync_n, output breq_n, output ad_in);
  modport core (input tick, input mid, input clk_out, input ack_direct_n,
    input ack_dsync_n, input breq_n, input ad_in);
endinterface
`default_nettype wire

// File: lb_target_model.sv
`timescale 1ns/100ps
`default_nettype none
module lb_target_model (
  input wire logic clk,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic pol,
  input wire logic [1:0] size,
  input wire logic ack_en,
  input wire logic [4:0] low_addr,
  input wire logic [31:0] ad_o,
  output logic [31:0] rdata,
  output logic ack_n
);
  logic [7:0] mem [32];
  logic [31:0] last = 32'h0;
  logic [2:0] cnt = 3'h0;
  logic [4:0] base;
  logic rd;
  logic wr;
  // strobes count only while this select is active, in its own polarity
  assign rd = (sel_n == pol) && (rd_n == pol);
  assign wr = (sel_n == pol) && (wr_n == pol);
  // unit address from the low lines only, aligned to the port size
  assign base = low_addr & ~((5'h01 << size) - 5'h01);
  // no pull on the data lines: show the inverse of the last value when idle
  assign rdata = rd ? {mem[base + 5'h03], mem[base + 5'h02], mem[base + 5'h01],
    mem[base]} : ~last;
  // slow answer, four clocks into the strobe; pulled high otherwise
  assign ack_n = !(ack_en && cnt == 3'h4);
  // unit bytes arrive in the low lanes
  always @(posedge clk) begin
    if (rd) last <= rdata;
    cnt <= (rd || wr) ? ((cnt == 3'h4) ? cnt : cnt + 3'h1) : 3'h0;
    if (wr) for (int i = 0; i < 4; i++) if (i < (1 << size)) mem[base + 5'(i)] <= ad_o[8*i +: 8];
  end
endmodule
`default_nettype wire

// File: local_bus_master.sv
// Contract
// R01: every cycle starts by asserting frame low
// R02: others stay off bus while frame low
// R03: address on bus, latch strobe first half
// R04: byte addresses; device LSB per width
// R05: first clock low lines carry byte enables
// R06: non-block: low lines carry address 4:0
// R07: select and strobe after first clock, polarity
// R08: strobe ends by width or ready; frame ends
// R09: idle gap before next frame
// R10: wide request splits into port-size cycles
// R11: split cycles own controls, never interleaved
// R12: skip empty units, one host clock each
// R13: block gives 32, 16 or 8 transfers
// R14: block: one frame, one latch, repeated strobe
// R15: block low lines increment per unit
// R16: block asserts all byte enables
// R17: block devices wire low address lines
// R18: low lines may replace latch below 32 bytes
// R19: word-only boards may skip low lines
// R20: external masters only with arbitration enable
// R21: local clock is host clock over four/two
// R22: ready direct or double-synchronised, extends signals
// R23: 12-bit watchdog ends cycle, raises interrupt
// R24: per-select timing for every cycle phase
// R25: phases counted by loaded down-counter
`timescale 1ns/100ps
`default_nettype none
module local_bus_master (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [lb_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [31:0] MUXED_ADDR_DATA_I,
  output logic [31:0] MUXED_ADDR_DATA_O,
  output logic MUXED_ADDR_DATA_OE_N,
  output logic CYCLE_FRAME_N,
  output logic ADDR_LATCH_STROBE,
  output logic [4:0] LOW_ADDR_BE,
  output logic [lb_pkg::NUM_SEL-1:0] DEVICE_SELECT_N,
  output logic READ_STROBE_N,
  output logic WRITE_STROBE_N,
  output logic LOCAL_BUS_OE_N,
  input wire logic TARGET_ACK_N,
  input wire logic BUS_REQUEST_N,
  output logic BUS_GRANT_N,
  output logic LOCAL_CLOCK_OUT,
  output logic TIMEOUT_IRQ
);
  import lb_pkg::*;

  // port mask in bytes for a size code
  function automatic logic [3:0] fn_pmask(input logic [1:0] lg);
    fn_pmask = (lg == 2'h0) ? 4'h1 : ((lg == 2'h1) ? 4'h3 : 4'hF);
  endfunction

  // byte mask to bit mask
  function automatic logic [31:0] fn_expand(input logic [3:0] m);
    fn_expand = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  lb_sync_if sif ();
  logic [31:0] cfg_ff;
  logic [31:0] addr_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [31:0] tim_ff [NUM_SEL];
  logic [31:0] buf_ff [BUF_WORDS];
  logic pend_ff, tmo_ff, irq_ff, grant_ff, gnt_n_ff;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  lb_state_t st_ff, nxt_st;
  logic [4:0] unit_ff, nxt_unit;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [WD_W-1:0] wd_ff, nxt_wd;
  logic frame_n_ff, nxt_frame_n, ale_ff, nxt_ale, sel_on_ff, nxt_sel_on;
  logic stb_on_ff, nxt_stb_on, ad_oe_n_ff, nxt_ad_oe_n;
  logic [4:0] la_ff, nxt_la;
  logic [31:0] ad_o_ff, nxt_ad_o;
  logic [NUM_SEL-1:0] dsel_ff;
  logic rd_n_ff, wr_n_ff, tmo_evt, rd_cap;

  lb_clock_div u_div (
    .clk(REF_CLK),
    .rst(RST),
    .div2(cfg_ff[CFG_DIV2_BIT]),
    .sif(sif.divider)
  );

  lb_pin_sync u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .ack_n(TARGET_ACK_N),
    .breq_n(BUS_REQUEST_N),
    .ad_in(MUXED_ADDR_DATA_I),
    .sif(sif.sync)
  );

  // apb decode; answer comes one cycle into the access phase
  wire apb_acc = PSEL & PENABLE & ~pready_ff;
  wire apb_wr = PSEL & PENABLE & pready_ff & PWRITE;
  wire aligned = PADDR[1:0] == 2'h0;
  wire buf_hit = aligned & (PADDR >= BUF_OFS) & (PADDR < BUF_END);
  wire tim_hit = aligned & (PADDR >= TIM_OFS) & (PADDR < TIM_END);
  wire [2:0] bidx = 3'(PADDR[11:2] - BUF_OFS[11:2]);
  wire [2:0] tidx = 3'(PADDR[11:2] - TIM_OFS[11:2]);
  wire cfg_sel = PADDR == CFG_OFS;
  wire addr_sel = PADDR == ADDR_OFS;
  wire ctrl_sel = PADDR == CTRL_OFS;
  wire stat_sel = PADDR == STAT_OFS;
  wire hit = cfg_sel | addr_sel | ctrl_sel | stat_sel | buf_hit | tim_hit;
  wire busy = (st_ff != ST_IDLE) | pend_ff;
  wire [31:0] stat_word = {29'h0, grant_ff, tmo_ff, busy};
  wire [31:0] rd_word = cfg_sel ? cfg_ff :
                        addr_sel ? addr_ff :
                        ctrl_sel ? {23'h0, ctrl_ff} :
                        stat_sel ? stat_word :
                        buf_hit ? buf_ff[bidx] :
                        tim_hit ? tim_ff[tidx] : 32'h0000_0000;

  // request fields and the active select's timing
  wire [3:0] req_be = ctrl_ff[CTRL_BE_LSB +: 4];
  wire req_wr = ctrl_ff[CTRL_WR_BIT];
  wire req_blk = ctrl_ff[CTRL_BLK_BIT];
  wire [2:0] req_sel = ctrl_ff[CTRL_SEL_LSB +: 3];
  wire [31:0] tcur = tim_ff[req_sel];
  wire [1:0] lg = (tcur[TM_SIZE_LSB +: 2] > 2'h2) ? 2'h2 : tcur[TM_SIZE_LSB +: 2];
  wire rdy_mode = tcur[TM_RDY_BIT];
  wire rdy_n = tcur[TM_RSYNC_BIT] ? sif.ack_dsync_n : sif.ack_direct_n; // R22
  wire [3:0] pmask = fn_pmask(lg);

  // unit position: block counts through 32 bytes, others through one word
  wire [4:0] unit_last = req_blk ? (BLOCK_UNITS_LAST >> lg) : (WORD_UNITS_LAST >> lg); // R10 R13
  wire [4:0] off = 5'(unit_ff << lg);
  wire [31:0] unit_addr = req_blk ? {addr_ff[31:5], off} : {addr_ff[31:2], off[1:0]}; // R04
  wire [3:0] unit_be = 4'(req_be >> off[1:0]) & pmask;
  wire need = req_blk | (|unit_be); // R12
  wire [3:0] be_on = req_blk ? 4'hF : unit_be; // R16
  wire [4:0] la_first = {unit_addr[4], ~be_on}; // R05
  wire [4:0] sh = {off[1:0], 3'h0};
  wire [31:0] wdata_unit = buf_ff[off[4:2]] >> sh;
  wire [31:0] rmask = fn_expand(pmask) << sh;
  wire [31:0] rmerge = (buf_ff[off[4:2]] & ~rmask) | ((sif.ad_in << sh) & rmask);
  wire last_unit = unit_ff == unit_last;

  // timed phases: a field of 0 or 1 lasts one local clock
  wire tend = sif.tick & (cnt_ff <= 4'h1); // R25
  wire wd_out = wd_ff == {WD_W{1'b0}};
  wire stb_end = sif.tick & (rdy_mode ? (~rdy_n | wd_out) : (cnt_ff <= 4'h1)); // R08
  wire nxt_grant = grant_ff ? ~sif.breq_n :
    (st_ff == ST_IDLE) & ~pend_ff & cfg_ff[CFG_ARB_BIT] & ~sif.breq_n; // R20 R11

  // cycle sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_unit = unit_ff;
    nxt_cnt = (sif.tick && cnt_ff != 4'h0) ? 4'(cnt_ff - 4'h1) : cnt_ff;
    nxt_wd = (sif.tick && !wd_out) ? WD_W'(wd_ff - 1'b1) : wd_ff; // R23
    nxt_frame_n = frame_n_ff;
    nxt_ale = ale_ff;
    nxt_la = la_ff;
    nxt_sel_on = sel_on_ff;
    nxt_stb_on = stb_on_ff;
    nxt_ad_o = ad_o_ff;
    nxt_ad_oe_n = ad_oe_n_ff;
    tmo_evt = 1'b0;
    rd_cap = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        if (pend_ff && !grant_ff) begin
          nxt_st = ST_CHECK;
          nxt_unit = 5'h00;
        end
      end
      ST_CHECK: begin
        if (!need) begin
          // one host clock spent on a unit with no enables
          if (last_unit) begin
            nxt_st = ST_IDLE;
          end else begin
            nxt_unit = 5'(unit_ff + 5'h01); // R12
          end
        end else if (sif.tick) begin
          nxt_st = ST_ADDR;
          nxt_frame_n = 1'b0; // R01
          nxt_ale = 1'b1; // R03 R14
          nxt_la = la_first; // R05
          nxt_ad_o = unit_addr; // R03
          nxt_ad_oe_n = 1'b0;
          nxt_wd = cfg_ff[CFG_WD_LSB +: WD_W]; // R23
        end
      end
      ST_ADDR: begin
        if (sif.mid) begin
          nxt_ale = 1'b0; // R03
        end
        if (sif.tick) begin
          nxt_st = ST_CS_SETUP;
          nxt_cnt = {1'b0, tcur[TM_CSON_LSB +: 3]}; // R24
          nxt_la = unit_addr[4:0]; // R06 R15
          nxt_ad_o = wdata_unit;
          nxt_ad_oe_n = ~req_wr;
        end
      end
      ST_CS_SETUP: begin
        if (tend) begin
          nxt_st = ST_STB_SETUP;
          nxt_sel_on = 1'b1; // R07
          nxt_cnt = {1'b0, tcur[TM_CONSET_LSB +: 3]}; // R24
        end
      end
      ST_STB_SETUP: begin
        if (tend) begin
          nxt_st = ST_STROBE;
          nxt_stb_on = 1'b1; // R07
          nxt_cnt = tcur[TM_WID_LSB +: 4];
        end
      end
      ST_STROBE: begin
        // ready mode holds every signal until ack or watchdog
        if (stb_end) begin
          nxt_stb_on = 1'b0; // R08
          rd_cap = ~req_wr;
          tmo_evt = rdy_mode & rdy_n & wd_out; // R23
          if (req_blk && !last_unit) begin
            nxt_st = ST_BURST_GAP; // R14
            nxt_unit = 5'(unit_ff + 5'h01); // R13
            nxt_cnt = tcur[TM_SUBW_LSB +: 4];
          end else begin
            nxt_st = ST_CS_HOLD;
            nxt_cnt = {1'b0, tcur[TM_COFH_LSB +: 3]};
          end
        end
      end
      ST_BURST_GAP: begin
        nxt_la = unit_addr[4:0]; // R15
        nxt_ad_o = wdata_unit;
        if (tend) begin
          nxt_st = ST_STROBE;
          nxt_stb_on = 1'b1; // R14
          nxt_cnt = tcur[TM_WID_LSB +: 4];
        end
      end
      ST_CS_HOLD: begin
        if (tend) begin
          nxt_st = ST_ADDR_HOLD;
          nxt_sel_on = 1'b0;
          nxt_cnt = {1'b0, tcur[TM_CSOFF_LSB +: 3]}; // R24
        end
      end
      ST_ADDR_HOLD: begin
        if (tend) begin
          nxt_st = ST_IDLE_GAP;
          nxt_frame_n = 1'b1; // R08
          nxt_ad_oe_n = 1'b1;
          nxt_cnt = tcur[TM_IDLE_LSB +: 4];
        end
      end
      ST_IDLE_GAP: begin
        // no new frame until the gap has run out
        if (tend) begin
          if (!req_blk && !last_unit) begin
            nxt_st = ST_CHECK; // R09 R11
            nxt_unit = 5'(unit_ff + 5'h01); // R10
          end else begin
            nxt_st = ST_IDLE; // R09
          end
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= ST_IDLE;
      unit_ff <= 5'h00;
      cnt_ff <= 4'h0;
      wd_ff <= {WD_W{1'b0}};
      frame_n_ff <= 1'b1;
      ale_ff <= 1'b0;
      la_ff <= 5'h1F;
      sel_on_ff <= 1'b0;
      stb_on_ff <= 1'b0;
      ad_o_ff <= 32'h0000_0000;
      ad_oe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      unit_ff <= nxt_unit;
      cnt_ff <= nxt_cnt;
      wd_ff <= nxt_wd;
      frame_n_ff <= nxt_frame_n;
      ale_ff <= nxt_ale;
      la_ff <= nxt_la;
      sel_on_ff <= nxt_sel_on;
      stb_on_ff <= nxt_stb_on;
      ad_o_ff <= nxt_ad_o;
      ad_oe_n_ff <= nxt_ad_oe_n;
    end
  end

  // select and strobe pins in each select's own polarity
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dsel_ff <= {NUM_SEL{1'b1}};
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_SEL; i++) begin
        dsel_ff[i] <= ~((nxt_sel_on && req_sel == 3'(i)) ^ tim_ff[i][TM_POL_BIT]); // R07
      end
      rd_n_ff <= ~((nxt_stb_on & ~req_wr) ^ tcur[TM_POL_BIT]);
      wr_n_ff <= ~((nxt_stb_on & req_wr) ^ tcur[TM_POL_BIT]);
    end
  end

  // software registers; request fields frozen while a request runs
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= CFG_RST;
      addr_ff <= 32'h0000_0000;
      ctrl_ff <= {CTRL_W{1'b0}};
      pend_ff <= 1'b0;
      for (int i = 0; i < NUM_SEL; i++) begin
        tim_ff[i] <= TIM_RST;
      end
    end else begin
      if (apb_wr && cfg_sel) cfg_ff <= PWDATA;
      if (apb_wr && tim_hit) tim_ff[tidx] <= PWDATA;
      if (apb_wr && addr_sel && !busy) addr_ff <= PWDATA;
      if (apb_wr && ctrl_sel && !busy) ctrl_ff <= PWDATA[CTRL_W-1:0];
      if (apb_wr && ctrl_sel && !busy && PWDATA[CTRL_GO_BIT]) begin
        pend_ff <= 1'b1;
      end else if (st_ff == ST_IDLE && !grant_ff) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // data buffer: write data from software, read data from the bus
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_ff[i] <= 32'h0000_0000;
      end
    end else if (rd_cap) begin
      buf_ff[off[4:2]] <= rmerge;
    end else if (apb_wr && buf_hit && !busy) begin
      buf_ff[bidx] <= PWDATA;
    end
  end

  // timeout flag: a new event wins over a clear in the same cycle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tmo_ff <= 1'b0;
      irq_ff <= 1'b0;
      grant_ff <= 1'b0;
      gnt_n_ff <= 1'b1;
    end else begin
      tmo_ff <= tmo_evt | (tmo_ff & ~(apb_wr & stat_sel & PWDATA[STAT_TMO_BIT]));
      irq_ff <= tmo_ff & cfg_ff[CFG_IRQEN_BIT]; // R23
      grant_ff <= nxt_grant; // R20
      gnt_n_ff <= ~nxt_grant;
    end
  end

  // apb answer
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc & ~hit;
      prdata_ff <= apb_acc ? rd_word : 32'h0000_0000;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign MUXED_ADDR_DATA_O = ad_o_ff;
  assign MUXED_ADDR_DATA_OE_N = ad_oe_n_ff;
  assign CYCLE_FRAME_N = frame_n_ff;
  assign ADDR_LATCH_STROBE = ale_ff;
  assign LOW_ADDR_BE = la_ff;
  assign DEVICE_SELECT_N = dsel_ff;
  assign READ_STROBE_N = rd_n_ff;
  assign WRITE_STROBE_N = wr_n_ff;
  assign LOCAL_BUS_OE_N = grant_ff; // high only while an external master owns the bus
  assign BUS_GRANT_N = gnt_n_ff;
  assign LOCAL_CLOCK_OUT = sif.clk_out;
  assign TIMEOUT_IRQ = irq_ff;
endmodule
`default_nettype wire

// File: local_bus_master_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module local_bus_master_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CYCLE_FRAME_N,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic [lb_pkg::NUM_SEL-1:0] DEVICE_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic LOCAL_CLOCK_OUT,
  input wire logic BUS_GRANT_N
);
  import lb_pkg::*;
  // one domain, so one clock and one reset for all checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  frame_latch_a: assert property ($rose(ADDR_LATCH_STROBE) |-> $fell(CYCLE_FRAME_N))
    else $error("latch pulse outside a frame start");
  latch_half_a: assert property ($rose(ADDR_LATCH_STROBE) |-> ##2 !ADDR_LATCH_STROBE)
    else $error("latch pulse longer than half a local clock");
  select_late_a: assert property ($fell(CYCLE_FRAME_N) |->
    ($stable(DEVICE_SELECT_N) && $stable(READ_STROBE_N) && $stable(WRITE_STROBE_N)) [*2])
    else $error("select or strobe moved in the first clock");
  frame_end_a: assert property ($rose(CYCLE_FRAME_N) |->
    $stable(DEVICE_SELECT_N) && $stable(READ_STROBE_N) && $stable(WRITE_STROBE_N))
    else $error("frame ended before select and strobe");
  idle_gap_a: assert property ($rose(CYCLE_FRAME_N) |-> CYCLE_FRAME_N [*4])
    else $error("new frame inside the idle gap");
  frame_edge_a: assert property ($fell(CYCLE_FRAME_N) |-> $rose(LOCAL_CLOCK_OUT))
    else $error("frame not aligned to the local clock");
  clock_high_a: assert property ($rose(LOCAL_CLOCK_OUT) |-> ##[1:4] $fell(LOCAL_CLOCK_OUT))
    else $error("local clock high too long");
  clock_low_a: assert property ($fell(LOCAL_CLOCK_OUT) |-> ##[1:4] $rose(LOCAL_CLOCK_OUT))
    else $error("local clock low too long");
  grant_quiet_a: assert property (!BUS_GRANT_N |-> CYCLE_FRAME_N)
    else $error("frame while the bus is granted");
endmodule

bind local_bus_master local_bus_master_checker i_local_bus_master_checker (
  .REF_CLK(REF_CLK), .RST(RST), .CYCLE_FRAME_N(CYCLE_FRAME_N),
  .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE), .DEVICE_SELECT_N(DEVICE_SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
  .LOCAL_CLOCK_OUT(LOCAL_CLOCK_OUT), .BUS_GRANT_N(BUS_GRANT_N));
`default_nettype wire

// File: local_bus_master_tb.sv
`timescale 1ns/100ps
`default_nettype none
module local_bus_master_tb;
  import lb_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_n = 1'b1;
  logic ack_en = 1'b0, pol = 1'b0, err, fr_q, st_q, sel_hi;
  logic pready, pslverr, ad_oe_n, frame_n, ale, rd_n, wr_n, ack_n, grant_n, irq, bus_oe_n;
  logic [1:0] size = 2'h0;
  logic [4:0] low, first_be;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, ad_o, ad_i, md, rv, first_ad;
  logic [NUM_SEL-1:0] sel_n;
  int errors = 0, check_count = 0, frames = 0, strobes = 0;
  // design reads its own drive, else whatever the target puts there
  assign ad_i = ad_oe_n ? md : ad_o;
  local_bus_master i_local_bus_master (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MUXED_ADDR_DATA_I(ad_i), .MUXED_ADDR_DATA_O(ad_o),
    .MUXED_ADDR_DATA_OE_N(ad_oe_n), .CYCLE_FRAME_N(frame_n), .ADDR_LATCH_STROBE(ale),
    .LOW_ADDR_BE(low), .DEVICE_SELECT_N(sel_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .LOCAL_BUS_OE_N(bus_oe_n), .TARGET_ACK_N(ack_n), .BUS_REQUEST_N(req_n), .BUS_GRANT_N(grant_n),
    .LOCAL_CLOCK_OUT(), .TIMEOUT_IRQ(irq));
  lb_target_model i_lb_target_model (.clk(ref_clk), .sel_n(sel_n[2]), .rd_n(rd_n), .wr_n(wr_n),
    .pol(pol), .size(size), .ack_en(ack_en), .low_addr(low), .ad_o(ad_o), .rdata(md),
    .ack_n(ack_n));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  // frame and strobe edge counters, first-clock enables
  always @(posedge ref_clk) begin
    fr_q <= frame_n;
    st_q <= rd_n & wr_n;
    if (fr_q && !frame_n) frames++;
    if (fr_q && !frame_n) {first_be, first_ad} = {low, ad_o};
    if (st_q && !(rd_n & wr_n)) strobes++;
    if (!frame_n && sel_n[2] && !rd_n) sel_hi = 1'b1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // model polarity follows only once the design's select pins have switched
  task automatic tim(input logic [31:0] v);
    apb(1'b1, TIM_OFS + 12'h008, v);
    size <= v[2:1];
    pol <= v[0];
  endtask

  // start a request on select 2 and poll until busy drops
  task automatic go(input logic [31:0] a, input logic [8:0] c);
    apb(1'b1, ADDR_OFS, a);
    frames = 0;
    strobes = 0;
    sel_hi = 1'b0;
    apb(1'b1, CTRL_OFS, {1'b1, 22'h0, c});
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
    end while (rv[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    $display("unexpected run length: expected end seen hang");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, CFG_OFS, 32'h0);
    chk("config", CFG_RST, rv);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    // word to a byte device splits, read back merges; partial enables skip units
    apb(1'b1, BUF_OFS, 32'hA1B2C3D4);
    tim(32'h0);
    go(32'h100, {3'h2, 2'b01, 4'hF});
    chk("split frames", 32'h4, 32'(frames));
    chk("stored", 32'hA1B2C3D4, {i_lb_target_model.mem[3], i_lb_target_model.mem[2],
      i_lb_target_model.mem[1], i_lb_target_model.mem[0]});
    apb(1'b1, BUF_OFS, 32'h0);
    go(32'h100, {3'h2, 2'b00, 4'hF});
    apb(1'b0, BUF_OFS, 32'h0);
    chk("read merge", 32'hA1B2C3D4, rv);
    go(32'h100, {3'h2, 2'b01, 4'h5});
    chk("enabled units", 32'h2, 32'(frames));
    tim(32'h2);
    go(32'h100, {3'h2, 2'b01, 4'hF});
    chk("half frames", 32'h2, 32'(frames));
    // block write to a byte device, block read back as words
    for (int i = 0; i < 8; i++) apb(1'b1, BUF_OFS + 12'(4 * i), 32'h03020100 + 32'h04040404 * i);
    tim(32'h0);
    go(32'h200, {3'h2, 2'b11, 4'hF});
    chk("block frames", 32'h1, 32'(frames));
    chk("byte strobes", 32'd32, 32'(strobes));
    chk("block enables", 32'h0, {28'h0, first_be[3:0]});
    for (int k = 0; k < 32; k++) chk("block byte", 32'(k), {24'h0, i_lb_target_model.mem[k]});
    for (int i = 0; i < 8; i++) apb(1'b1, BUF_OFS + 12'(4 * i), 32'h0);
    tim(32'h4);
    go(32'h200, {3'h2, 2'b10, 4'hF});
    chk("word strobes", 32'h8, 32'(strobes));
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, BUF_OFS + 12'(4 * i), 32'h0);
      chk("block read", 32'h03020100 + 32'h04040404 * i, rv);
    end
    // silent target in ready mode: watchdog ends the cycle
    apb(1'b1, CFG_OFS, 32'h0001_0004);
    tim(32'hC);
    go(32'h100, {3'h2, 2'b00, 4'h1});
    chk("timeout flag", 32'h1, {31'h0, rv[STAT_TMO_BIT]});
    chk("timeout irq", 32'h1, {31'h0, irq});
    apb(1'b1, STAT_OFS, 32'h2);
    ack_en <= 1'b1;
    tim(32'h1C);
    apb(1'b1, CFG_OFS, 32'h0040_0004);
    go(32'h100, {3'h2, 2'b00, 4'h1});
    chk("acked cycle", 32'h0, {31'h0, rv[STAT_TMO_BIT]});
    chk("bus address", 32'h100, first_ad);
    // active-high select and strobe, then a split write with the local clock at host over two
    apb(1'b1, BUF_OFS, 32'h5A);
    tim(32'h1);
    go(32'h300, {3'h2, 2'b01, 4'h1});
    chk("high select", 32'h1, {31'h0, sel_hi});
    chk("high strobe", 32'h5A, {24'h0, i_lb_target_model.mem[0]});
    apb(1'b1, CFG_OFS, 32'h1);
    tim(32'h0);
    go(32'h100, {3'h2, 2'b01, 4'hF});
    chk("fast frames", 32'h4, 32'(frames));
    // external request honoured only with arbitration enabled
    req_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("no grant", 32'h1, {31'h0, grant_n});
    chk("bus driven", 32'h0, {31'h0, bus_oe_n});
    apb(1'b1, CFG_OFS, 32'h2);
    repeat (20) @(posedge ref_clk);
    chk("grant", 32'h0, {31'h0, grant_n});
    chk("bus released", 32'h1, {31'h0, bus_oe_n});
    stop_test();
  end
endmodule
`default_nettype wire
